// ### fifo_ctrl.sv
`timescale 1ns/1ps
`include "fifo_defs.svh"
// Overview of operation
// - Rewind without a mark returns the read pointer to location zero.
// - Rewind drives empty low, or output-ready inactive in fall-through mode.
// - Rewind leaves write pointer, modes and offsets untouched.
// - Rewind with a recorded mark loads the read pointer with the mark.
// - Each shift-clock rise with shift enable shifts serial bit into offsets, unless a parallel offset write lands in the same cycle.
// - Offsets shift only while shift enable is asserted by the host.
// - Synchronous writes happen on a clock edge only with write enable active.
// - Each enabled synchronous write with LOAD_N high stores the input word into the FIFO unless it is full.
// - Write select acts as second enable; both must be active to write.
// - Asynchronous mode writes on each strobe rise while not full; host holds enable low.
// - In standard mode, reads happen on a clock edge only while read enable is active.
module fifo_ctrl import fifo_pkg::*; #(
  parameter int DATA_W = `FIFO_DATA_W,
  parameter int ADDR_W = `FIFO_ADDR_W
) (
  // Clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              RST,
  // Mode straps, caught once after reset
  input  wire logic              FIRST_WORD_FALLTHROUGH,
  input  wire logic              WRITE_ASYNC,
  // Write port
  input  wire logic [DATA_W-1:0] DATA_IN,
  input  wire logic              WEN_N,
  input  wire logic              WRITE_SELECT_N,
  input  wire logic              WRITE_STROBE,
  input  wire logic              LOAD_N,
  // Read port
  input  wire logic              REN_N,
  input  wire logic              REWIND_REQUEST,
  input  wire logic              MARK,
  output logic      [DATA_W-1:0] DATA_OUT,
  // Serial offset load
  input  wire logic              OFFSET_SHIFT_CLK,
  input  wire logic              OFFSET_SHIFT_ENABLE_N,
  input  wire logic              OFFSET_SERIAL_IN,
  // Status flags
  output logic                   EMPTY_FLAG_N,
  output logic                   OUTPUT_READY_N,
  output logic                   FULL_FLAG_N,
  output logic                   ALMOST_EMPTY_N,
  output logic                   ALMOST_FULL_N
);
  localparam int PW    = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;

  if (ADDR_W < `OFS_W || ADDR_W > 20) $error("fifo_ctrl: ADDR_W out of range");
  if (DATA_W <= `OFS_W) $error("fifo_ctrl: DATA_W must exceed offset width");

  // ****************************************
  // Declarations
  // ****************************************
  run_state_t        state_r;
  run_state_t        state_nxt;
  logic              first_word_fallthrough_r;
  logic              first_word_fallthrough_nxt;
  logic              async_r;
  logic              async_nxt;
  logic              running;

  logic [PW-1:0]     wr_ptr_r;
  logic [PW-1:0]     wr_ptr_nxt;
  logic [PW-1:0]     rd_ptr_r;
  logic [PW-1:0]     rd_ptr_nxt;
  logic [PW-1:0]     mark_ptr_r;
  logic [PW-1:0]     mark_ptr_nxt;
  logic              mark_valid_r;
  logic              mark_valid_nxt;
  logic              valid_r;
  logic              valid_nxt;
  logic [DATA_W-1:0] dout_r;
  logic [DATA_W-1:0] dout_nxt;
  logic              ofs_wsel_r;
  logic              ofs_wsel_nxt;
  logic              ofs_rsel_r;
  logic              ofs_rsel_nxt;
  flags_t            flags_r;
  flags_t            flags_nxt;

  logic [DATA_W-1:0] mem_r [DEPTH];

  logic              strobe_rise;
  logic              shift_rise;
  logic              wr_try;
  logic              wr_mem;
  logic              ofs_we;
  logic              ofs_shift;
  logic              rewind;
  logic              rd_try;
  logic              pull;
  logic              mem_empty;
  logic              full;
  logic [PW-1:0]     cnt_nxt;
  logic [PW-1:0]     ae_lim;
  logic [PW-1:0]     af_lim;
  offsets_t          offs;
  logic [2*`OFS_W-1:0] offs_bits;

  // ****************************************
  // Edge detection and offset storage
  // ****************************************
  // Strobe and shift clock are sampled pins, so each must stay
  // below half the system clock rate to be seen
  rise_detect #(.W(1)) u_strobe_edge (
    .clk   (SYS_CLK),
    .rst   (RST),
    .level (WRITE_STROBE),
    .rise  (strobe_rise)
  );

  rise_detect #(.W(1)) u_shift_edge (
    .clk   (SYS_CLK),
    .rst   (RST),
    .level (OFFSET_SHIFT_CLK),
    .rise  (shift_rise)
  );

  offset_loader u_offsets (
    .clk       (SYS_CLK),
    .rst       (RST),
    .shift_en  (ofs_shift),
    .shift_bit (OFFSET_SERIAL_IN),
    .par_we    (ofs_we),
    .par_sel   (ofs_wsel_r),
    .par_data  (DATA_IN[`OFS_W-1:0]),
    .offs      (offs)
  );

  assign offs_bits = offs;

  // ****************************************
  // Mode capture
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    first_word_fallthrough_nxt  = first_word_fallthrough_r;
    async_nxt = async_r;
    unique case (state_r)
      ST_STRAP: begin
        first_word_fallthrough_nxt  = FIRST_WORD_FALLTHROUGH;
        async_nxt = WRITE_ASYNC;
        state_nxt = ST_RUN;
      end
      ST_RUN: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_r <= ST_STRAP;
      first_word_fallthrough_r  <= 1'b0;
      async_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      first_word_fallthrough_r  <= first_word_fallthrough_nxt;
      async_r <= async_nxt;
    end
  end

  assign running = (state_r == ST_RUN);

  // ****************************************
  // Write side and pointers
  // ****************************************
  always_comb begin
    mem_empty    = (wr_ptr_r == rd_ptr_r);
    full         = (wr_ptr_r - rd_ptr_r) == PW'(DEPTH);
    wr_try       = running && (async_r ? strobe_rise : 1'b1)
                   && !WEN_N && !WRITE_SELECT_N;
    wr_mem       = wr_try && LOAD_N && !full;
    ofs_we       = wr_try && !LOAD_N;
    ofs_shift    = running && shift_rise && !OFFSET_SHIFT_ENABLE_N;
    wr_ptr_nxt   = wr_mem ? wr_ptr_r + 1'b1 : wr_ptr_r;
    ofs_wsel_nxt = ofs_we ? ~ofs_wsel_r : ofs_wsel_r;
  end

  // Memory is bare storage; no reset keeps it cheap
  always_ff @(posedge SYS_CLK) begin
    if (wr_mem) begin
      mem_r[wr_ptr_r[ADDR_W-1:0]] <= DATA_IN;
    end
  end

  // ****************************************
  // Read side, mark and rewind
  // ****************************************
  always_comb begin
    rewind = running && REWIND_REQUEST;
    rd_try = running && !REN_N && !rewind;
    if (first_word_fallthrough_r) begin
      pull = running && !rewind && LOAD_N && !mem_empty && (!valid_r || !REN_N);
    end else begin
      pull = rd_try && LOAD_N && !mem_empty;
    end
    // Rewind touches only the read side; writes and offsets go on
    if (rewind) begin
      rd_ptr_nxt = mark_valid_r ? mark_ptr_r : '0;
    end else if (pull) begin
      rd_ptr_nxt = rd_ptr_r + 1'b1;
    end else begin
      rd_ptr_nxt = rd_ptr_r;
    end
    if (rewind) begin
      valid_nxt = 1'b0;
    end else if (pull) begin
      valid_nxt = 1'b1;
    end else if (first_word_fallthrough_r && rd_try && LOAD_N) begin
      valid_nxt = 1'b0;
    end else begin
      valid_nxt = valid_r;
    end
    if (pull) begin
      dout_nxt = mem_r[rd_ptr_r[ADDR_W-1:0]];
    end else if (rd_try && !LOAD_N) begin
      dout_nxt = {{(DATA_W-`OFS_W){1'b0}},
                  ofs_rsel_r ? offs.almost_full : offs.almost_empty};
    end else begin
      dout_nxt = dout_r;
    end
    ofs_rsel_nxt   = (rd_try && !LOAD_N) ? ~ofs_rsel_r : ofs_rsel_r;
    mark_valid_nxt = running && MARK;
    mark_ptr_nxt   = (MARK && !mark_valid_r) ? rd_ptr_r : mark_ptr_r;
  end

  // ****************************************
  // Flags
  // ****************************************
  always_comb begin
    cnt_nxt                 = wr_ptr_nxt - rd_ptr_nxt;
    ae_lim                  = PW'(offs.almost_empty);
    af_lim                  = PW'(DEPTH) - PW'(offs.almost_full);
    flags_nxt.empty_n       = !rewind && (cnt_nxt != '0) && running;
    flags_nxt.ready_n       = !(first_word_fallthrough_r && valid_nxt);
    flags_nxt.full_n        = cnt_nxt != PW'(DEPTH);
    flags_nxt.almost_empty_n = cnt_nxt > ae_lim;
    flags_nxt.almost_full_n = cnt_nxt < af_lim;
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      wr_ptr_r     <= '0;
      rd_ptr_r     <= '0;
      mark_ptr_r   <= '0;
      mark_valid_r <= 1'b0;
      valid_r      <= 1'b0;
      dout_r       <= '0;
      ofs_wsel_r   <= 1'b0;
      ofs_rsel_r   <= 1'b0;
      flags_r      <= '{empty_n: 1'b0, ready_n: 1'b1, full_n: 1'b1,
                        almost_empty_n: 1'b0, almost_full_n: 1'b1};
    end else begin
      wr_ptr_r     <= wr_ptr_nxt;
      rd_ptr_r     <= rd_ptr_nxt;
      mark_ptr_r   <= mark_ptr_nxt;
      mark_valid_r <= mark_valid_nxt;
      valid_r      <= valid_nxt;
      dout_r       <= dout_nxt;
      ofs_wsel_r   <= ofs_wsel_nxt;
      ofs_rsel_r   <= ofs_rsel_nxt;
      flags_r      <= flags_nxt;
    end
  end

  assign DATA_OUT       = dout_r;
  assign EMPTY_FLAG_N   = flags_r.empty_n;
  assign OUTPUT_READY_N = flags_r.ready_n;
  assign FULL_FLAG_N    = flags_r.full_n;
  assign ALMOST_EMPTY_N = flags_r.almost_empty_n;
  assign ALMOST_FULL_N  = flags_r.almost_full_n;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  property p_rewind_zero;
    rewind && !mark_valid_r |=> rd_ptr_r == '0;
  endproperty
  a_rewind_zero: assert property (p_rewind_zero) else $error("rewind missed zero");

  property p_rewind_flag;
    rewind |=> (first_word_fallthrough_r ? OUTPUT_READY_N : !EMPTY_FLAG_N);
  endproperty
  a_rewind_flag: assert property (p_rewind_flag) else $error("rewind flag wrong");

  property p_rewind_keeps;
    rewind && !wr_mem && !ofs_we && !ofs_shift
      |=> $stable(wr_ptr_r) && $stable(offs_bits) && $stable(first_word_fallthrough_r) && $stable(async_r);
  endproperty
  a_rewind_keeps: assert property (p_rewind_keeps) else $error("rewind disturbed state");

  property p_rewind_mark;
    rewind && mark_valid_r |=> rd_ptr_r == $past(mark_ptr_r);
  endproperty
  a_rewind_mark: assert property (p_rewind_mark) else $error("rewind missed mark");

  property p_serial_shift;
    ofs_shift && !ofs_we
      |=> offs_bits == {$past(offs_bits[2*`OFS_W-2:0]), $past(OFFSET_SERIAL_IN)};
  endproperty
  a_serial_shift: assert property (p_serial_shift) else $error("serial shift wrong");

  property p_shift_gate;
    !ofs_shift && !ofs_we |=> $stable(offs_bits);
  endproperty
  a_shift_gate: assert property (p_shift_gate) else $error("offsets changed unasked");

  property p_sync_wen;
    !async_r && WEN_N |=> $stable(wr_ptr_r);
  endproperty
  a_sync_wen: assert property (p_sync_wen) else $error("write without enable");

  property p_sync_store;
    wr_mem && !async_r |=> mem_r[$past(wr_ptr_r[ADDR_W-1:0])] == $past(DATA_IN);
  endproperty
  a_sync_store: assert property (p_sync_store) else $error("word not stored");

  property p_select;
    WRITE_SELECT_N |=> $stable(wr_ptr_r);
  endproperty
  a_select: assert property (p_select) else $error("write while deselected");

  property p_async_strobe;
    running && async_r && strobe_rise && !WEN_N && !WRITE_SELECT_N && LOAD_N && !full
      |=> wr_ptr_r == $past(wr_ptr_r) + 1'b1;
  endproperty
  a_async_strobe: assert property (p_async_strobe) else $error("strobe write lost");

  property p_read_gate;
    !first_word_fallthrough_r && REN_N && !rewind |=> $stable(rd_ptr_r) && $stable(dout_r);
  endproperty
  a_read_gate: assert property (p_read_gate) else $error("read without enable");

  property p_full_ignore;
    full && wr_try && !pull && !rewind |=> $stable(wr_ptr_r) && !FULL_FLAG_N;
  endproperty
  a_full_ignore: assert property (p_full_ignore) else $error("write while full");

  c_rewind_mark: cover property (rewind && mark_valid_r);
  c_full:        cover property (full && wr_try);
  c_serial:      cover property (ofs_shift);
  c_first_word_fallthrough_read:   cover property (first_word_fallthrough_r && pull && valid_r);
endmodule

// ### fifo_defs.svh
`ifndef FIFO_DEFS_SVH
`define FIFO_DEFS_SVH

// ****************************************
// Widths
// ****************************************
`define FIFO_DATA_W 36
`define FIFO_ADDR_W 10
`define OFS_W       10

// ****************************************
// Offset field positions in offsets_t
// ****************************************
`define OFS_AE_LSB  0
`define OFS_AF_LSB  10

// ****************************************
// Reset values
// ****************************************
`define AE_OFS_RST  10'h07F
`define AF_OFS_RST  10'h07F

`endif

// ### fifo_pkg.sv
package fifo_pkg;
  `include "fifo_defs.svh"

  // ****************************************
  // Carriers
  // ****************************************
  // Almost-full sits above almost-empty, so serial bits flow AF first
  typedef struct packed {
    logic [`OFS_W-1:0] almost_full;
    logic [`OFS_W-1:0] almost_empty;
  } offsets_t;

  typedef struct packed {
    logic empty_n;
    logic ready_n;
    logic full_n;
    logic almost_empty_n;
    logic almost_full_n;
  } flags_t;

  // ****************************************
  // Mode capture states
  // ****************************************
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN   = 2'b10
  } run_state_t;
endpackage

// ### rise_detect.sv
`timescale 1ns/1ps
module rise_detect import fifo_pkg::*; #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Sampled level and its rising edge
  input  wire logic [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] prev_r;
  logic [W-1:0] prev_nxt;

  initial begin
    if (W < 1) $error("rise_detect: W must be at least 1");
  end

  always_comb begin
    prev_nxt = level;
    rise     = level & ~prev_r;
  end

  // Reset to ones so a level already high at release is no edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_r <= {W{1'b1}};
    end else begin
      prev_r <= prev_nxt;
    end
  end
endmodule

// ### offset_loader.sv
`timescale 1ns/1ps
`include "fifo_defs.svh"
module offset_loader import fifo_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial load
  input  wire logic              shift_en,
  input  wire logic              shift_bit,
  // Parallel load
  input  wire logic              par_we,
  input  wire logic              par_sel,
  input  wire logic [`OFS_W-1:0] par_data,
  // Current offsets
  output offsets_t               offs
);
  offsets_t offs_r;
  offsets_t offs_nxt;

  // Parallel write wins; both at once is a host fault
  always_comb begin
    offs_nxt = offs_r;
    if (par_we) begin
      if (par_sel) begin
        offs_nxt.almost_full = par_data;
      end else begin
        offs_nxt.almost_empty = par_data;
      end
    end else if (shift_en) begin
      offs_nxt = {offs_r[2*`OFS_W-2:0], shift_bit};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offs_r <= '{almost_full: `AF_OFS_RST, almost_empty: `AE_OFS_RST};
    end else begin
      offs_r <= offs_nxt;
    end
  end

  assign offs = offs_r;
endmodule

// ### offset_host.sv
`timescale 1ns/1ps
module offset_host (
  // Clock
  input  wire logic        clk,
  // Frame request
  input  wire logic        start,
  input  wire logic [19:0] value,
  output logic             busy,
  // Serial pins
  output logic             sclk,
  output logic             sen_n,
  output logic             sdi
);
  // ****************************************
  // Frame generator
  // ****************************************
  int i;

  initial begin
    busy  = 1'h0;
    sclk  = 1'h0;
    sen_n = 1'h1;
    sdi   = 1'h0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'h1;
        for (i = 20; i >= 0; i--) begin
          // Leading pulse with enable off must shift nothing
          sen_n <= (i == 20);
          sdi   <= value[(i == 20) ? 19 : i] ^ (i == 20);
          repeat (2) @(posedge clk);
          sclk <= 1'h1;
          repeat (2) @(posedge clk);
          sclk <= 1'h0;
        end
        // Released line shows the inverse, not a stale bit
        sen_n <= 1'h1;
        sdi   <= ~value[0];
        busy  <= 1'h0;
      end
    end
  end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench import fifo_pkg::*;;
  // ****************************************
  // Signals
  // ****************************************
  logic        clk        = 1'h0;
  logic        rst        = 1'h1;
  logic        first_word_fallthrough       = 1'h0;
  logic        wasync     = 1'h0;
  logic [35:0] din        = 36'h0;
  logic        wen_n      = 1'h1;
  logic        ws_n       = 1'h1;
  logic        wstb       = 1'h0;
  logic        load_n     = 1'h1;
  logic        ren_n      = 1'h1;
  logic        rew        = 1'h0;
  logic        mark       = 1'h0;
  logic        ostart     = 1'h0;
  logic [19:0] ovalue     = 20'h0;
  logic [31:0] seed       = 32'h00000059;
  logic        obusy, sclk, sen_n, sdi;
  logic        ef_n, or_n, ff_n, ae_n, af_n;
  logic [35:0] dout;
  logic [35:0] q[$];
  logic [31:0] x;
  logic [19:0] ov;
  int          rp         = 0;
  int          mp;
  int          i;
  int          n_mismatch = 0;
  int          checks     = 0;

  always #4 clk = ~clk;

  fifo_ctrl dut (
    .SYS_CLK(clk), .RST(rst), .FIRST_WORD_FALLTHROUGH(first_word_fallthrough), .WRITE_ASYNC(wasync),
    .DATA_IN(din), .WEN_N(wen_n), .WRITE_SELECT_N(ws_n), .WRITE_STROBE(wstb),
    .LOAD_N(load_n), .REN_N(ren_n), .REWIND_REQUEST(rew), .MARK(mark), .DATA_OUT(dout),
    .OFFSET_SHIFT_CLK(sclk), .OFFSET_SHIFT_ENABLE_N(sen_n), .OFFSET_SERIAL_IN(sdi),
    .EMPTY_FLAG_N(ef_n), .OUTPUT_READY_N(or_n), .FULL_FLAG_N(ff_n),
    .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n)
  );

  offset_host u_host (
    .clk(clk), .start(ostart), .value(ovalue), .busy(obusy),
    .sclk(sclk), .sen_n(sen_n), .sdi(sdi)
  );

  // ****************************************
  // Helpers
  // ****************************************
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function logic [35:0] ofs_exp(input logic [19:0] v, input logic hi);
    return {26'h0, hi ? v[19:10] : v[9:0]};
  endfunction

  // Almost flags as {ae_n, af_n} for a fill count and offsets {AF, AE}
  function logic [1:0] almost_exp(input int cnt, input logic [19:0] v);
    return {cnt > int'(v[9:0]), cnt < 1024 - int'(v[19:10])};
  endfunction

  task close_out();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task give_up();
    n_mismatch++;
    $display("MISMATCH t=%0t wait ran out", $time);
    close_out();
  endtask

  task chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task do_reset(input logic f, input logic a);
    @(posedge clk);
    rst    <= 1'h1;
    first_word_fallthrough   <= f;
    wasync <= a;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    // Straps are caught at the first edge after release
    @(posedge clk);
    q.delete();
    rp = 0;
  endtask

  task wr(input logic [35:0] d, input logic we, input logic cs);
    @(posedge clk);
    din   <= d;
    wen_n <= we;
    ws_n  <= cs;
    if (!we && !cs && q.size() - rp < 1024)
      q.push_back(d);
  endtask

  task swr(input logic [35:0] d);
    @(posedge clk);
    din  <= d;
    wstb <= 1'h0;
    repeat (2) @(posedge clk);
    wstb <= 1'h1;
    q.push_back(d);
    @(posedge clk);
  endtask

  task rd(input logic ld, input logic [35:0] e);
    @(posedge clk);
    ren_n  <= 1'h0;
    load_n <= ld;
    @(posedge clk);
    ren_n  <= 1'h1;
    load_n <= 1'h1;
    #1;
    chk(dout, e);
    if (ld)
      rp++;
  endtask

  task rd_ofs(input logic [19:0] v);
    rd(1'h0, ofs_exp(v, 1'h0));
    rd(1'h0, ofs_exp(v, 1'h1));
  endtask

  task rewind();
    @(posedge clk);
    rew <= 1'h1;
    @(posedge clk);
    rew <= 1'h0;
    #1;
  endtask

  task load_ofs(input logic [19:0] v);
    int n;
    n = 0;
    @(posedge clk);
    ovalue <= v;
    ostart <= 1'h1;
    @(posedge clk);
    ostart <= 1'h0;
    #1;
    while (obusy !== 1'h0 && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n == 200)
      give_up();
  endtask

  task wait_or();
    int n;
    n = 0;
    while (or_n !== 1'h0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 20)
      give_up();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    do_reset(1'h0, 1'h0);
    rd_ofs({10'h07F, 10'h07F});
    // First four writes forced so rewind has words to revisit
    for (i = 0; i < 40; i++) begin
      x = xs();
      wr({x[3:0], xs()}, (i > 3) & x[4], (i > 3) & x[5]);
    end
    wr(36'h0, 1'h1, 1'h1);
    #1;
    chk({35'h0, ef_n}, 36'h1);
    chk({34'h0, ae_n, af_n}, {34'h0, almost_exp(q.size() - rp, {10'h07F, 10'h07F})});
    x = xs();
    ov = x[19:0];
    load_ofs(ov);
    rd_ofs(ov);
    for (i = 0; i < 3; i++)
      rd(1'h1, q[rp]);
    rewind();
    chk({35'h0, ef_n}, 36'h0);
    rp = 0;
    rd_ofs(ov);
    rd(1'h1, q[rp]);
    rd(1'h1, q[rp]);
    @(posedge clk);
    mark <= 1'h1;
    mp = rp;
    rd(1'h1, q[rp]);
    rd(1'h1, q[rp]);
    rewind();
    rp = mp;
    rd(1'h1, q[rp]);
    @(posedge clk);
    mark <= 1'h0;
    while (rp < q.size())
      rd(1'h1, q[rp]);
    chk({35'h0, ef_n}, 36'h0);
    q.delete();
    rp = 0;
    for (i = 0; i < 1025; i++) begin
      x = xs();
      wr({x[3:0], xs()}, 1'h0, 1'h0);
    end
    wr(36'h0, 1'h1, 1'h1);
    #1;
    chk({35'h0, ff_n}, 36'h0);
    chk({34'h0, ae_n, af_n}, {34'h0, almost_exp(q.size() - rp, ov)});
    while (rp < q.size())
      rd(1'h1, q[rp]);
    chk({34'h0, ae_n, af_n}, {34'h0, almost_exp(q.size() - rp, ov)});
    // Parallel offset writes: AE first, then AF, swapped halves of ov
    @(posedge clk);
    load_n <= 1'h0;
    din    <= {26'h0, ov[19:10]};
    wen_n  <= 1'h0;
    ws_n   <= 1'h0;
    @(posedge clk);
    din    <= {26'h0, ov[9:0]};
    @(posedge clk);
    wen_n  <= 1'h1;
    ws_n   <= 1'h1;
    load_n <= 1'h1;
    rd_ofs({ov[9:0], ov[19:10]});
    do_reset(1'h1, 1'h1);
    @(posedge clk);
    wen_n <= 1'h0;
    ws_n  <= 1'h0;
    for (i = 0; i < 3; i++) begin
      x = xs();
      swr({x[3:0], xs()});
    end
    wstb <= 1'h0;
    wait_or();
    chk(dout, q[0]);
    rewind();
    chk({35'h0, or_n}, 36'h1);
    wait_or();
    chk(dout, q[0]);
    @(posedge clk);
    ren_n <= 1'h0;
    @(posedge clk);
    ren_n <= 1'h1;
    #1;
    chk(dout, q[1]);
    close_out();
  end
endmodule
